//--- hw/bia_ctl.sv
// Bridge init and audio slot control registers with AXI4-Lite slave and TDM framing
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bia_ctl
  import bia_pkg::*;
#(
  parameter int NVM_BYTES = 128,
  parameter int LANES     = 4,
  parameter int SLOT_BITS = 32
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [AXI_ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          strap_pin_a,
  input  wire logic                          strap_pin_b,
  output logic                               nvm_rd_req,
  output logic [$clog2(NVM_BYTES)-1:0]       nvm_rd_addr,
  input  wire logic [7:0]                    nvm_rd_data,
  input  wire logic                          nvm_rd_valid,
  output bia_video_sel_t                     video_sel,
  output bia_audio_sel_t                     audio_sel,
  input  wire logic                          bit_clock,
  input  wire logic [LANES*SLOT_BITS-1:0]    lane_words,
  output logic                               frame_sync_out,
  output logic                               primary_sound_data_line,
  input  wire logic                          frame_sync_in,
  input  wire logic                          tdm_data_in,
  output logic [LANES*SLOT_BITS-1:0]         split_words,
  output logic                               split_valid,
  output logic                               irq
);
  localparam int FRAME = LANES * SLOT_BITS;
  localparam int POS_W = $clog2(FRAME);
  localparam int NA_W  = $clog2(NVM_BYTES);
  localparam logic [POS_W-1:0] POS_LAST = POS_W'(FRAME - 1);
  localparam logic [POS_W-1:0] POS_HALF = POS_W'(FRAME / 2);
  localparam logic [POS_W-1:0] POS_SLOT = POS_W'(SLOT_BITS);
  localparam logic [NA_W-1:0]  NVM_LAST = NA_W'(NVM_BYTES - 1);
  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             awready, wready, aw_held, w_held, w_lane0, bvalid, arready, rvalid;
    logic [IDX_W-1:0] aw_idx;
    logic [7:0]       w_byte, ctl, src, split, slot, sum;
    logic [1:0]       bresp, rresp, strap_cnt;
    logic [31:0]      rdata;
    logic             cfg_done, init_done, sum_pass, irq, strap_done, nvm_req;
    logic [IRQ_W-1:0] irq_sts, irq_mask;
    logic             sa_s1, sa_s2, sb_s1, sb_s2, bc_s1, bc_s2, bc_s3, fi_s1, fi_s2;
    logic             di_s1, di_s2, tx_prev, fs_out, tdm_out, fs_prev, rx_run, rx_valid;
    bia_init_t        ist;
    logic [NA_W-1:0]  nvm_addr;
    logic [POS_W-1:0] tx_pos, rx_pos;
    logic [FRAME-1:0] tx_frame, rx_sr, rx_words;
  } bia_state_t;
  bia_state_t s_reg;
  bia_state_t s_next;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_VIDEO_BRIDGE_CONTROL, IDX_INIT_STS, IDX_AUDIO_SRC, IDX_AUDIO_SPLIT,
      IDX_SLOT_FRAME, IDX_IRQ_STATUS, IDX_IRQ_MASK: idx_mapped = 1'h1;
      default: idx_mapped = 1'h0;
    endcase
  endfunction
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] wmask);
    merge = (old_v & ~wmask) | (new_v & wmask);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic             do_wr, do_rd, reload_set, bc_edge, tx_on, cur_bit, fs_act, fs_start;
    logic             dly, pol, take;
    logic [IDX_W-1:0] ridx;
    logic [7:0]       rval;
    logic [IRQ_W-1:0] ev, w1c;
    logic [POS_W-1:0] rpos;
    s_next     = s_reg;
    do_wr      = 1'h0;
    do_rd      = 1'h0;
    ridx       = s_axi_araddr[AXI_ADDR_W-1:2];
    rval       = 8'h00;
    reload_set = 1'h0;
    ev         = '0;
    w1c        = '0;
    cur_bit    = 1'h0;
    fs_act     = 1'h0;
    fs_start   = 1'h0;
    take       = 1'h0;
    rpos       = '0;
    dly        = s_reg.slot[SLOT_DLY_BIT];
    pol        = s_reg.slot[SLOT_POL_BIT];
    bc_edge    = s_reg.bc_s2 && !s_reg.bc_s3;
    tx_on      = s_reg.src[SRC_TDM_BIT] && s_reg.src[SRC_I2S_BIT];
    // AXI4-Lite write channel
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'h1;
      s_next.aw_idx  = s_axi_awaddr[AXI_ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_held  = 1'h1;
      s_next.w_byte  = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
      do_wr          = s_reg.w_lane0 && idx_mapped(s_reg.aw_idx);
      s_next.aw_held = 1'h0;
      s_next.w_held  = 1'h0;
      s_next.bvalid  = 1'h1;
      s_next.bresp   = idx_mapped(s_reg.aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'h0;
    end
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready  = !s_next.w_held && !s_next.bvalid;
    // Register writes, reserved bits masked off
    if (do_wr) begin
      case (s_reg.aw_idx)
        IDX_VIDEO_BRIDGE_CONTROL: begin
          s_next.ctl = merge(s_reg.ctl, s_reg.w_byte, CTL_WMASK & ~(8'h01 << CTL_RELOAD_BIT));
          reload_set = s_reg.w_byte[CTL_RELOAD_BIT];
        end
        IDX_AUDIO_SRC:   s_next.src      = merge(s_reg.src, s_reg.w_byte, SRC_WMASK);
        IDX_AUDIO_SPLIT: s_next.split    = merge(s_reg.split, s_reg.w_byte, SPLIT_WMASK);
        IDX_SLOT_FRAME:  s_next.slot     = merge(s_reg.slot, s_reg.w_byte, SLOT_WMASK);
        IDX_IRQ_STATUS:  w1c             = s_reg.w_byte[IRQ_W-1:0];
        IDX_IRQ_MASK:    s_next.irq_mask = s_reg.w_byte[IRQ_W-1:0];
        default: ;
      endcase
    end
    // AXI4-Lite read channel
    if (s_axi_arvalid && s_reg.arready) begin
      do_rd = 1'h1;
    end
    case (ridx)
      IDX_VIDEO_BRIDGE_CONTROL:  rval = s_reg.ctl;
      IDX_INIT_STS: begin
        rval[STS_INIT_BIT] = s_reg.init_done;
        rval[STS_CFG_BIT]  = s_reg.cfg_done;
        rval[STS_SUM_BIT]  = s_reg.sum_pass;
      end
      IDX_AUDIO_SRC:   rval = s_reg.src;
      IDX_AUDIO_SPLIT: rval = s_reg.split;
      IDX_SLOT_FRAME:  rval = s_reg.slot;
      IDX_IRQ_STATUS:  rval[IRQ_W-1:0] = s_reg.irq_sts;
      IDX_IRQ_MASK:    rval[IRQ_W-1:0] = s_reg.irq_mask;
      default:         rval = 8'h00;
    endcase
    if (do_rd) begin
      s_next.rvalid = 1'h1;
      s_next.rdata  = {24'h000000, rval};
      s_next.rresp  = idx_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'h0;
    end
    s_next.arready = !s_next.rvalid;
    // Strap capture after reset release
    s_next.sa_s1 = strap_pin_a;
    s_next.sa_s2 = s_reg.sa_s1;
    s_next.sb_s1 = strap_pin_b;
    s_next.sb_s2 = s_reg.sb_s1;
    if (!s_reg.strap_done) begin
      if (s_reg.strap_cnt == STRAP_SETTLE) begin
        s_next.ctl[CTL_MAP_BIT]     = s_reg.sb_s2;
        s_next.ctl[CTL_ARRANGE_BIT] = s_reg.sa_s2;
        s_next.strap_done           = 1'h1;
        reload_set                  = 1'h1;
      end else begin
        s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      end
    end
    // Configuration reload sequencer
    s_next.nvm_req = 1'h0;
    case (s_reg.ist)
      INIT_IDLE: begin
        if (s_reg.ctl[CTL_RELOAD_BIT]) begin
          s_next.cfg_done  = 1'h0;
          s_next.init_done = 1'h0;
          s_next.sum       = 8'h00;
          s_next.nvm_addr  = '0;
          s_next.ist       = INIT_REQ;
        end
      end
      INIT_REQ: begin
        s_next.nvm_req = 1'h1;
        s_next.ist     = INIT_WAIT;
      end
      INIT_WAIT: begin
        if (nvm_rd_valid) begin
          s_next.sum = s_reg.sum + nvm_rd_data;
          if (s_reg.nvm_addr == NVM_LAST) begin
            s_next.ist = INIT_CFG;
          end else begin
            s_next.nvm_addr = s_reg.nvm_addr + NA_W'(1);
            s_next.ist      = INIT_REQ;
          end
        end
      end
      INIT_CFG: begin
        s_next.cfg_done = 1'h1;
        s_next.sum_pass = (s_reg.sum == 8'h00);
        ev[IRQ_SUMFAIL_BIT] = (s_reg.sum != 8'h00);
        s_next.ist      = INIT_FIN;
      end
      INIT_FIN: begin
        s_next.init_done = 1'h1;
        s_next.ctl[CTL_RELOAD_BIT] = 1'h0;
        ev[IRQ_INIT_BIT] = 1'h1;
        s_next.ist       = INIT_IDLE;
      end
      default: s_next.ist = INIT_IDLE;
    endcase
    if (reload_set) begin
      s_next.ctl[CTL_RELOAD_BIT] = 1'h1;
    end
    // Interrupt status, set wins over clear
    s_next.irq_sts = (s_reg.irq_sts & ~w1c) | ev;
    s_next.irq     = |(s_next.irq_sts & s_next.irq_mask);
    // Audio pin synchronisers
    s_next.bc_s1 = bit_clock;
    s_next.bc_s2 = s_reg.bc_s1;
    s_next.bc_s3 = s_reg.bc_s2;
    s_next.fi_s1 = frame_sync_in;
    s_next.fi_s2 = s_reg.fi_s1;
    s_next.di_s1 = tdm_data_in;
    s_next.di_s2 = s_reg.di_s1;
    // Lane to TDM serializer
    if (!tx_on) begin
      s_next.tx_pos  = '0;
      s_next.tx_prev = 1'h0;
      s_next.fs_out  = pol;
      s_next.tdm_out = 1'h0;
    end else if (bc_edge) begin
      cur_bit = s_reg.tx_frame[POS_LAST - s_reg.tx_pos];
      s_next.tx_prev = cur_bit;
      s_next.tdm_out = dly ? s_reg.tx_prev : cur_bit;
      case (s_reg.slot[SLOT_WID_LSB +: 2])
        FSW_HALF: fs_act = (s_reg.tx_pos < POS_HALF);
        FSW_SLOT: fs_act = (s_reg.tx_pos < POS_SLOT);
        default:  fs_act = (s_reg.tx_pos == '0);
      endcase
      s_next.fs_out = fs_act ^ pol;
      if (s_reg.tx_pos == POS_LAST) begin
        s_next.tx_pos   = '0;
        s_next.tx_frame = lane_words;
      end else begin
        s_next.tx_pos = s_reg.tx_pos + POS_W'(1);
      end
    end
    // TDM to lane splitter
    s_next.rx_valid = 1'h0;
    if (!s_reg.split[SPLIT_EN_BIT]) begin
      s_next.rx_run  = 1'h0;
      s_next.rx_pos  = '0;
      s_next.fs_prev = 1'h0;
    end else if (bc_edge) begin
      fs_act         = s_reg.fi_s2 ^ pol;
      fs_start       = fs_act && !s_reg.fs_prev;
      s_next.fs_prev = fs_act;
      take           = dly ? s_reg.rx_run : (fs_start || s_reg.rx_run);
      rpos           = (fs_start && !dly) ? '0 : s_reg.rx_pos;
      if (take) begin
        s_next.rx_sr  = {s_reg.rx_sr[FRAME-2:0], s_reg.di_s2};
        s_next.rx_pos = rpos + POS_W'(1);
        if (rpos == POS_LAST) begin
          s_next.rx_words = {s_reg.rx_sr[FRAME-2:0], s_reg.di_s2};
          s_next.rx_valid = 1'h1;
          s_next.rx_run   = 1'h0;
        end
      end
      if (fs_start) begin
        s_next.rx_run = 1'h1;
        s_next.rx_pos = POS_W'(!dly);
      end
    end
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg            <= '0;
      s_reg.ctl        <= CTL_RST;
      s_reg.src        <= SRC_RST;
      s_reg.split      <= SPLIT_RST;
      s_reg.slot       <= SLOT_RST;
      s_reg.sum_pass   <= SUM_RST;
      s_reg.ist        <= INIT_IDLE;
      s_reg.awready    <= 1'h1;
      s_reg.wready     <= 1'h1;
      s_reg.arready    <= 1'h1;
    end else begin
      s_reg <= s_next;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign nvm_rd_req    = s_reg.nvm_req;
  assign nvm_rd_addr   = s_reg.nvm_addr;
  assign video_sel.video_bit_map_select    = s_reg.ctl[CTL_MAP_BIT];
  assign video_sel.pixel_input_arrangement = s_reg.ctl[CTL_ARRANGE_BIT];
  assign video_sel.video_port_exchange     = s_reg.ctl[CTL_EXCHANGE_BIT];
  assign audio_sel.audio_enable            = s_reg.src[SRC_I2S_BIT];
  assign audio_sel.tdm_serialize           = s_reg.src[SRC_TDM_BIT];
  assign audio_sel.tdm_split               = s_reg.split[SPLIT_EN_BIT];
  assign frame_sync_out          = s_reg.fs_out;
  assign primary_sound_data_line = s_reg.tdm_out;
  assign split_words             = s_reg.rx_words;
  assign split_valid             = s_reg.rx_valid;
  assign irq                     = s_reg.irq;
endmodule

`default_nettype wire

//--- hw/bia_pkg.sv
// Register map, field layout and shared types of the bridge init and audio slot control block
package bia_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int             AXI_ADDR_W      = 9;
  localparam int             IDX_W           = 7;
  localparam logic [IDX_W-1:0] IDX_VIDEO_BRIDGE_CONTROL  = 7'h4F;
  localparam logic [IDX_W-1:0] IDX_INIT_STS    = 7'h50;
  localparam logic [IDX_W-1:0] IDX_AUDIO_SRC   = 7'h54;
  localparam logic [IDX_W-1:0] IDX_AUDIO_SPLIT = 7'h55;
  localparam logic [IDX_W-1:0] IDX_SLOT_FRAME  = 7'h57;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 7'h60;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 7'h61;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_MAP_BIT      = 7;
  localparam int CTL_ARRANGE_BIT  = 6;
  localparam int CTL_EXCHANGE_BIT = 5;
  localparam int CTL_RELOAD_BIT   = 1;
  localparam int STS_INIT_BIT     = 4;
  localparam int STS_CFG_BIT      = 2;
  localparam int STS_SUM_BIT      = 1;
  localparam int SRC_TDM_BIT      = 2;
  localparam int SRC_I2S_BIT      = 1;
  localparam int SPLIT_EN_BIT     = 7;
  localparam int SLOT_POL_BIT     = 3;
  localparam int SLOT_DLY_BIT     = 2;
  localparam int SLOT_WID_LSB     = 0;
  localparam int IRQ_INIT_BIT     = 0;
  localparam int IRQ_SUMFAIL_BIT  = 1;
  localparam int IRQ_W            = 2;

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_WMASK   = 8'hE2;
  localparam logic [7:0] SRC_WMASK   = 8'h06;
  localparam logic [7:0] SPLIT_WMASK = 8'h80;
  localparam logic [7:0] SLOT_WMASK  = 8'h0F;
  localparam logic [7:0] CTL_RST     = 8'h00;
  localparam logic [7:0] SRC_RST     = 8'h02;
  localparam logic [7:0] SPLIT_RST   = 8'h00;
  localparam logic [7:0] SLOT_RST    = 8'h02;
  localparam logic       SUM_RST     = 1'h1;

  // ----------------------------------------------------------------
  // Frame sync width codes, bus answers, timing
  // ----------------------------------------------------------------
  localparam logic [1:0] FSW_HALF    = 2'h0;
  localparam logic [1:0] FSW_SLOT    = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    INIT_IDLE,
    INIT_REQ,
    INIT_WAIT,
    INIT_CFG,
    INIT_FIN
  } bia_init_t;

  typedef struct packed {
    logic video_bit_map_select;
    logic pixel_input_arrangement;
    logic video_port_exchange;
  } bia_video_sel_t;

  typedef struct packed {
    logic audio_enable;
    logic tdm_serialize;
    logic tdm_split;
  } bia_audio_sel_t;

endpackage

//--- testbench/bia_ctl_asserts.sv
// Port checker for the bridge init and audio slot control block
`timescale 1ns/1ps
`default_nettype none
module bia_ctl_asserts
  import bia_pkg::*;
#(
  parameter int NVM_BYTES = 128
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         s_axi_awvalid,
  input  wire logic                         s_axi_awready,
  input  wire logic                         s_axi_wvalid,
  input  wire logic                         s_axi_wready,
  input  wire logic [1:0]                   s_axi_bresp,
  input  wire logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic                         s_axi_arvalid,
  input  wire logic                         s_axi_arready,
  input  wire logic [31:0]                  s_axi_rdata,
  input  wire logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         nvm_rd_req,
  input  wire logic [$clog2(NVM_BYTES)-1:0] nvm_rd_addr,
  input  wire logic                         split_valid
);
  // ----
  // Last requested memory byte
  // ----
  logic [$clog2(NVM_BYTES)-1:0] last_addr_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) last_addr_reg <= '0;
    else if (nvm_rd_req) last_addr_reg <= nvm_rd_addr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while answering");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_nvm_pulse: assert property (nvm_rd_req |=> !nvm_rd_req) else $error("long request");
  a_nvm_step: assert property (nvm_rd_req && nvm_rd_addr != '0 |-> nvm_rd_addr == last_addr_reg + 1)
    else $error("memory address out of order");
  a_split_pulse: assert property (split_valid |=> !split_valid) else $error("long split pulse");
  c_split: cover property (split_valid);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_nvm_last: cover property (nvm_rd_req && (&nvm_rd_addr));
endmodule
bind bia_ctl bia_ctl_asserts #(.NVM_BYTES(NVM_BYTES)) bia_ctl_asserts_i (.*);
`default_nettype wire

//--- testbench/bia_partner.sv
// Far-side model: configuration memory and audio bit clock
`timescale 1ns/1ps
`default_nettype none
module bia_partner (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       nvm_rd_req,
  input  wire logic [6:0] nvm_rd_addr,
  input  wire logic       bad_sum,
  output logic [7:0]      nvm_rd_data,
  output logic            nvm_rd_valid,
  output logic            bit_clock
);
  // ----
  // Memory answers alternate prompt and slow
  // ----
  logic [7:0] byte_reg;
  logic [1:0] wait_reg;
  logic       pend_reg;
  logic       slow_reg;
  initial begin
    bit_clock = 1'b0;
    forever #70 bit_clock = ~bit_clock;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pend_reg, slow_reg, wait_reg, nvm_rd_valid} <= '0;
      byte_reg <= 8'h00;
    end else begin
      nvm_rd_valid <= 1'b0;
      if (nvm_rd_req) begin
        pend_reg <= 1'b1;
        wait_reg <= slow_reg ? 2'h2 : 2'h0;
        slow_reg <= ~slow_reg;
        // Image sums to zero unless a failure is asked for
        byte_reg <= (&nvm_rd_addr) ? (bad_sum ? 8'hC0 : 8'hBF) : {1'b0, nvm_rd_addr};
      end else if (pend_reg) begin
        if (wait_reg == 2'h0) begin
          pend_reg <= 1'b0;
          nvm_rd_valid <= 1'b1;
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end
    end
  end
  assign nvm_rd_data = nvm_rd_valid ? byte_reg : ~byte_reg;
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the bridge init and audio slot control block
`timescale 1ns/1ps
`default_nettype none
module tb
  import bia_pkg::*;
;
  // ----
  // Signals
  // ----
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, bad_sum = 1'b0;
  logic strap_pin_a = 1'b0, strap_pin_b = 1'b0, split_on = 1'b0;
  logic [8:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic nvm_rd_req, nvm_rd_valid, bit_clock, frame_sync_out, primary_sound_data_line, split_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] nvm_rd_addr;
  logic [7:0] nvm_rd_data, last_rd;
  logic [127:0] lane_words = '0, split_words;
  logic [67:0] exp_q[$];
  bia_video_sel_t video_sel;
  bia_audio_sel_t audio_sel;
  int num_errors = 0, samples_checked = 0;
  always #10 aclk = ~aclk;
  bia_ctl bia_ctl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b),
    .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_data(nvm_rd_data),
    .nvm_rd_valid(nvm_rd_valid), .video_sel(video_sel), .audio_sel(audio_sel),
    .bit_clock(bit_clock), .lane_words(lane_words), .frame_sync_out(frame_sync_out),
    .primary_sound_data_line(primary_sound_data_line), .split_words(split_words),
    .frame_sync_in(frame_sync_out), .tdm_data_in(primary_sound_data_line),
    .split_valid(split_valid), .irq(irq));
  bia_partner bia_partner_i (.aclk(aclk), .aresetn(aresetn), .nvm_rd_req(nvm_rd_req),
    .nvm_rd_addr(nvm_rd_addr), .bad_sum(bad_sum), .nvm_rd_data(nvm_rd_data),
    .nvm_rd_valid(nvm_rd_valid), .bit_clock(bit_clock));
  // ----
  // Checking and bus tasks
  // ----
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic pop(input logic [33:0] got);
    logic [67:0] e;
    e = exp_q.pop_front();
    if (e[67:34] != '0) cmp(got & e[67:34], e[33:0] & e[67:34]);
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) pop({s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) pop({s_axi_bresp, 32'h0});
    if (s_axi_rvalid) last_rd <= s_axi_rdata[7:0];
    if (split_valid && split_on) cmp(split_words, lane_words);
  end
  task automatic axw(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    exp_q.push_back({34'h300000000, er, 32'h0});
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    if (n >= 100) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic axr(input logic [6:0] idx, input logic [7:0] e, input logic [7:0] m,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    exp_q.push_back({{26{|m}}, m, er, 24'h0, e});
    s_axi_araddr <= {idx, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    if (n >= 100) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic wait_init();
    int n;
    for (n = 0; n < 300; n++) begin
      axr(IDX_INIT_STS, 8'h00, 8'h00, RESP_OKAY);
      @(posedge aclk);
      if (last_rd[4]) break;
    end
    if (n >= 300) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic wait_split(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 3000) begin
      @(posedge aclk);
      n++;
      if (split_valid) begin
        k--;
        n = 0;
      end
    end
    if (k > 0) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // ----
  // Scenarios
  // ----
  logic [6:0] regs[3] = '{IDX_AUDIO_SRC, IDX_AUDIO_SPLIT, IDX_SLOT_FRAME};
  logic [7:0] rst_v[3] = '{8'h02, 8'h00, 8'h02};
  logic [7:0] wr_v[3] = '{8'h06, 8'h80, 8'h0F};
  initial begin
    void'($urandom(32'hE5B293D0));
    {strap_pin_a, strap_pin_b} = 2'($urandom);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(IDX_INIT_STS, 8'h00, 8'h14, RESP_OKAY);
    wait_init();
    axr(IDX_INIT_STS, 8'h16, 8'hFF, RESP_OKAY);
    axr(IDX_VIDEO_BRIDGE_CONTROL, {strap_pin_b, strap_pin_a, 6'h00}, 8'hFF, RESP_OKAY);
    cmp(video_sel, {strap_pin_b, strap_pin_a, 1'b0});
    cmp(audio_sel, 3'h4);
    for (int i = 0; i < 3; i++) begin
      axr(regs[i], rst_v[i], 8'hFF, RESP_OKAY);
      axw(regs[i], 8'hFF, RESP_OKAY);
      axr(regs[i], wr_v[i], 8'hFF, RESP_OKAY);
    end
    cmp(audio_sel, 3'h7);
    axr(IDX_IRQ_STATUS, 8'h01, 8'hFF, RESP_OKAY);
    cmp(irq, 1'b0);
    axr(7'h00, 8'h00, 8'hFF, RESP_SLVERR);
    axw(7'h00, 8'hFF, RESP_SLVERR);
    axw(IDX_INIT_STS, 8'hFF, RESP_OKAY);
    axr(IDX_INIT_STS, 8'h16, 8'hFF, RESP_OKAY);
    bad_sum <= 1'b1;
    axw(IDX_VIDEO_BRIDGE_CONTROL, 8'hFF, RESP_OKAY);
    axr(IDX_VIDEO_BRIDGE_CONTROL, 8'hE2, 8'hFF, RESP_OKAY);
    cmp(video_sel, 3'h7);
    wait_init();
    axr(IDX_INIT_STS, 8'h14, 8'hFF, RESP_OKAY);
    axr(IDX_VIDEO_BRIDGE_CONTROL, 8'hE0, 8'hFF, RESP_OKAY);
    axr(IDX_IRQ_STATUS, 8'h03, 8'hFF, RESP_OKAY);
    axw(IDX_IRQ_MASK, 8'h02, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(irq, 1'b1);
    axw(IDX_IRQ_STATUS, 8'h02, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(irq, 1'b0);
    for (int i = 0; i < 16; i++) begin
      lane_words <= {$urandom, $urandom, $urandom, $urandom};
      axw(IDX_SLOT_FRAME, 8'(i), RESP_OKAY);
      wait_split(3);
      split_on <= 1'b1;
      wait_split(1);
      split_on <= 1'b0;
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
